// >>> logic/frl_pkg.sv
// Package of constants for the fault record logger
// How it works
// - Upper nonvolatile half holds sixteen records
// - Entering a marked state starts a record
// - Snapshot taken as previous state exits
// - Used flag programmed to 0 when written
// - Record holds state, cause, status, checksum
// - Eight bytes, each about 250 us
// - Finish a record before any other
// - Power-on search finds first flag reading 1
// - Slots every eight bytes, 0xF980 to 0xF9F8
// - All slots used stops further writes
// - Host polls pending records in the status register
// - Erase then recorder reset repeats search
// - Snapshot latched on each state change
package frl_pkg;
  // ****************************************
  // Record area
  // ****************************************
  localparam logic [15:0] REC_BASE = 16'hf980; // First slot
  localparam logic [15:0] REC_LAST = 16'hf9f8; // Last slot
  localparam logic [15:0] REC_END = 16'hf9ff; // Top byte of area
  localparam int SLOT_W = 4; // Sixteen slots
  localparam int BYTE_W = 3; // Eight bytes per slot
  localparam int ST_W = 5; // Sequencer state number width
  localparam logic [2:0] FLAG_BYTE = 3'h7; // Flag byte offset, written last
  localparam int FLAG_BIT = 0; // Used flag position
  localparam logic [7:0] FLAG_USED = 8'hfe; // Flag byte value once used
  localparam logic [7:0] PAD_BYTE = 8'hff; // Spare byte left erased
  // ****************************************
  // Exit cause codes
  // ****************************************
  localparam logic [1:0] CAUSE_SEQ = 2'h1;
  localparam logic [1:0] CAUSE_TMO = 2'h2;
  localparam logic [1:0] CAUSE_MON = 2'h3;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ = 10000; // 10 MHz clock
  localparam int BYTE_PROG_US = 250; // Byte programming time
  localparam int BYTE_PROG_CYC = (BYTE_PROG_US * CLK_KHZ + 999) / 1000;
  localparam int CNT_W = 12;
  // ****************************************
  // APB registers
  // ****************************************
  localparam logic [7:0] REG_MASK = 8'h00; // Record state mask, RW
  localparam logic [7:0] REG_CMD = 8'h04; // Bit 0 restarts search, WO
  localparam logic [7:0] REG_STAT = 8'h08; // Status, RO
  localparam logic [31:0] MASK_RST = 32'h00000000;
  localparam int STAT_SLOT = 0; // [3:0] next free slot
  localparam int STAT_FULL = 4;
  localparam int STAT_BUSY = 5;
  localparam int STAT_SCAN = 6;
  localparam int STAT_PEND = 7; // Records waiting to be read
endpackage

// >>> logic/frl_snapshot.sv
// Compact status snapshot latched on each sequencer state change
`timescale 1ns/100ps
module frl_snapshot (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Sequencer side
  input wire logic step_i,
  input wire logic [frl_pkg::ST_W-1:0] state_i,
  input wire logic [1:0] cause_i,
  input wire logic [7:0] uv_i,
  input wire logic [7:0] ov_i,
  input wire logic [3:0] gpi_i,
  input wire logic [7:0] lim_i,
  // Latched snapshot of the state just left
  output logic [frl_pkg::ST_W-1:0] prev_o,
  output logic [1:0] cause_o,
  output logic [7:0] uv_o,
  output logic [7:0] ov_o,
  output logic [3:0] gpi_o,
  output logic [7:0] lim_o
);
  logic [frl_pkg::ST_W-1:0] cur_r, cur_nxt; // State now running
  logic [frl_pkg::ST_W+29:0] snap_r, snap_nxt; // Packed snapshot

  // Capture on the change edge; inputs still show the old state
  always_comb begin
    cur_nxt = cur_r;
    snap_nxt = snap_r;
    if (step_i) begin
      cur_nxt = state_i;
      snap_nxt = {cur_r, cause_i, uv_i, ov_i, gpi_i, lim_i};
    end
  end

  // Registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_r <= '0;
      snap_r <= '0;
    end else begin
      cur_r <= cur_nxt;
      snap_r <= snap_nxt;
    end
  end

  assign {prev_o, cause_o, uv_o, ov_o, gpi_o, lim_o} = snap_r;

  snap_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !step_i |=> $stable(snap_r)) else $error("snapshot moved without a state change");
endmodule

// >>> logic/frl_logger.sv
// Fault record logger: slot search, record writer and APB registers
`timescale 1ns/100ps
module frl_logger (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Sequencing engine
  input wire logic SEQ_STEP_I,
  input wire logic [frl_pkg::ST_W-1:0] SEQ_STATE_I,
  input wire logic [1:0] SEQ_CAUSE_I,
  input wire logic [7:0] UNDERVOLTAGE_STATUS_I,
  input wire logic [7:0] OVERVOLTAGE_STATUS_I,
  input wire logic [3:0] GENERAL_INPUT_LEVELS_I,
  input wire logic [7:0] ADC_LIMIT_STATUS_I,
  // Nonvolatile array byte port
  output logic EE_RD_O,
  output logic EE_WR_O,
  output logic [15:0] EE_ADDR_O,
  output logic [7:0] EE_WDATA_O,
  input wire logic [7:0] EE_RDATA_I,
  // Recorder status
  output logic REC_BUSY_O
);
  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic [2:0] {
    ST_SCAN_RD, ST_SCAN_CHK, ST_IDLE, ST_PREP, ST_PROG, ST_WAIT
  } frl_state_e;

  frl_state_e st_r, st_nxt; // Recorder phase
  logic [frl_pkg::SLOT_W-1:0] slot_r, slot_nxt; // Next free slot
  logic [frl_pkg::BYTE_W-1:0] byte_r, byte_nxt; // Byte within record
  logic [frl_pkg::CNT_W-1:0] cnt_r, cnt_nxt; // Programming wait
  logic full_r, full_nxt; // Every slot used
  logic rescan_r, rescan_nxt; // Search requested by software
  logic [7:0] rec_r [8]; // Record image
  logic [7:0] rec_nxt [8];
  logic ee_rd_nxt, ee_wr_nxt;
  logic [15:0] ee_addr_r, ee_addr_nxt;
  logic [7:0] ee_wdata_r, ee_wdata_nxt;
  logic [31:0] mask_r, mask_nxt; // States that write a record
  logic [31:0] prdata_r, prdata_nxt;
  logic slverr_r, slverr_nxt;
  logic ee_rd_r, ee_wr_r;
  logic trig; // Entry into a record state
  logic apb_wr, apb_setup, cmd_scan;
  logic [7:0] sum; // Running checksum
  logic [frl_pkg::ST_W-1:0] sn_prev;
  logic [1:0] sn_cause;
  logic [7:0] sn_uv, sn_ov, sn_lim;
  logic [3:0] sn_gpi;
  logic [frl_pkg::CNT_W-1:0] gap_r; // Helper for spacing check
  logic wr_seen_r;

  // ****************************************
  // Snapshot latch
  // ****************************************
  frl_snapshot u_snap (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .step_i(SEQ_STEP_I),
    .state_i(SEQ_STATE_I),
    .cause_i(SEQ_CAUSE_I),
    .uv_i(UNDERVOLTAGE_STATUS_I),
    .ov_i(OVERVOLTAGE_STATUS_I),
    .gpi_i(GENERAL_INPUT_LEVELS_I),
    .lim_i(ADC_LIMIT_STATUS_I),
    .prev_o(sn_prev),
    .cause_o(sn_cause),
    .uv_o(sn_uv),
    .ov_o(sn_ov),
    .gpi_o(sn_gpi),
    .lim_o(sn_lim)
  );

  // New state is a record state
  assign trig = SEQ_STEP_I && mask_r[SEQ_STATE_I];
  assign apb_setup = PSEL_I && !PENABLE_I;
  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign cmd_scan = apb_wr && (PADDR_I == frl_pkg::REG_CMD) && PWDATA_I[0];

  // ****************************************
  // Recorder sequencing
  // ****************************************
  // Search, capture and program; one record at a time
  always_comb begin
    st_nxt = st_r;
    slot_nxt = slot_r;
    byte_nxt = byte_r;
    cnt_nxt = cnt_r;
    full_nxt = full_r;
    rec_nxt = rec_r;
    ee_rd_nxt = 1'b0;
    ee_wr_nxt = 1'b0;
    ee_addr_nxt = ee_addr_r;
    ee_wdata_nxt = ee_wdata_r;
    sum = 8'h00;
    // Request kept until the search actually starts; set wins
    rescan_nxt = rescan_r || cmd_scan;
    unique case (st_r)
      // Read the flag byte of the slot under test
      ST_SCAN_RD: begin
        ee_rd_nxt = 1'b1;
        ee_addr_nxt = {frl_pkg::REC_BASE[15:7], slot_r, frl_pkg::FLAG_BYTE};
        st_nxt = ST_SCAN_CHK;
      end
      // Data is back while the read strobe is high, one cycle after the read is requested
      ST_SCAN_CHK: begin
        if (!ee_rd_r) begin
          st_nxt = ST_SCAN_CHK;
        end else if (EE_RDATA_I[frl_pkg::FLAG_BIT]) begin
          st_nxt = ST_IDLE;
        end else if (slot_r == '1) begin
          full_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end else begin
          slot_nxt = slot_r + 1'b1;
          st_nxt = ST_SCAN_RD;
        end
      end
      // Wait for a record state or a search request
      ST_IDLE: begin
        if (rescan_r) begin
          rescan_nxt = cmd_scan;
          slot_nxt = '0;
          full_nxt = 1'b0;
          st_nxt = ST_SCAN_RD;
        end else if (trig && !full_r) begin
          st_nxt = ST_PREP;
        end
      end
      // Freeze the snapshot into the record image
      ST_PREP: begin
        rec_nxt[0] = {sn_cause, 1'b0, sn_prev};
        rec_nxt[1] = sn_uv;
        rec_nxt[2] = sn_ov;
        rec_nxt[3] = {4'h0, sn_gpi};
        rec_nxt[4] = sn_lim;
        rec_nxt[5] = frl_pkg::PAD_BYTE;
        sum = 8'(rec_nxt[0] + rec_nxt[1] + rec_nxt[2] + rec_nxt[3]
          + rec_nxt[4] + rec_nxt[5]);
        rec_nxt[6] = 8'(-sum);
        rec_nxt[7] = frl_pkg::FLAG_USED;
        byte_nxt = '0;
        st_nxt = ST_PROG;
      end
      // Issue one byte program
      ST_PROG: begin
        ee_wr_nxt = 1'b1;
        ee_addr_nxt = {frl_pkg::REC_BASE[15:7], slot_r, byte_r};
        ee_wdata_nxt = rec_r[byte_r];
        cnt_nxt = frl_pkg::CNT_W'(frl_pkg::BYTE_PROG_CYC - 1);
        st_nxt = ST_WAIT;
      end
      // Hold off for the programming time; triggers here are ignored
      ST_WAIT: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else if (byte_r != frl_pkg::FLAG_BYTE) begin
          byte_nxt = byte_r + 1'b1;
          st_nxt = ST_PROG;
        end else begin
          // Flag byte done: slot is used
          if (slot_r == '1) begin
            full_nxt = 1'b1;
          end else begin
            slot_nxt = slot_r + 1'b1;
          end
          st_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // APB slave
  // ****************************************
  // Read data and error are set up in the setup phase; one wait-free access
  always_comb begin
    mask_nxt = mask_r;
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    if (apb_wr && (PADDR_I == frl_pkg::REG_MASK)) begin
      mask_nxt = PWDATA_I;
    end
    if (apb_setup) begin
      prdata_nxt = '0;
      slverr_nxt = 1'b0;
      if (PADDR_I == frl_pkg::REG_MASK) begin
        prdata_nxt = mask_r;
      end else if (PADDR_I == frl_pkg::REG_STAT) begin
        prdata_nxt[frl_pkg::STAT_SLOT +: frl_pkg::SLOT_W] = slot_r;
        prdata_nxt[frl_pkg::STAT_FULL] = full_r;
        prdata_nxt[frl_pkg::STAT_BUSY] = REC_BUSY_O;
        prdata_nxt[frl_pkg::STAT_SCAN] = (st_r == ST_SCAN_RD) || (st_r == ST_SCAN_CHK);
        prdata_nxt[frl_pkg::STAT_PEND] = full_r || (slot_r != '0);
      end else if (PADDR_I != frl_pkg::REG_CMD) begin
        slverr_nxt = 1'b1; // Unmapped address
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Reset lands in the search, so power-on always looks for a free slot
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      st_r <= ST_SCAN_RD;
      slot_r <= '0;
      byte_r <= '0;
      cnt_r <= '0;
      full_r <= 1'b0;
      rescan_r <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        rec_r[i] <= frl_pkg::PAD_BYTE;
      end
      ee_rd_r <= 1'b0;
      ee_wr_r <= 1'b0;
      ee_addr_r <= frl_pkg::REC_BASE;
      ee_wdata_r <= frl_pkg::PAD_BYTE;
      mask_r <= frl_pkg::MASK_RST;
      prdata_r <= '0;
      slverr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      slot_r <= slot_nxt;
      byte_r <= byte_nxt;
      cnt_r <= cnt_nxt;
      full_r <= full_nxt;
      rescan_r <= rescan_nxt;
      rec_r <= rec_nxt;
      ee_rd_r <= ee_rd_nxt;
      ee_wr_r <= ee_wr_nxt;
      ee_addr_r <= ee_addr_nxt;
      ee_wdata_r <= ee_wdata_nxt;
      mask_r <= mask_nxt;
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  // Outputs
  assign EE_RD_O = ee_rd_r;
  assign EE_WR_O = ee_wr_r;
  assign EE_ADDR_O = ee_addr_r;
  assign EE_WDATA_O = ee_wdata_r;
  assign PRDATA_O = prdata_r;
  assign PSLVERR_O = slverr_r && PSEL_I && PENABLE_I;
  assign PREADY_O = 1'b1;
  assign REC_BUSY_O = (st_r == ST_PREP) || (st_r == ST_PROG) || (st_r == ST_WAIT);

  // ****************************************
  // Checks
  // ****************************************
  // Cycles since the last byte program, for spacing checks
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      gap_r <= '0;
      wr_seen_r <= 1'b0;
    end else begin
      gap_r <= EE_WR_O ? 12'h001 : ((gap_r == '1) ? gap_r : gap_r + 1'b1);
      wr_seen_r <= wr_seen_r || EE_WR_O;
    end
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_capture;
    st_r == ST_PREP;
  endsequence
  sequence s_first_byte;
    st_r == ST_PROG && byte_r == '0 ##1 EE_WR_O && EE_ADDR_O[2:0] == 3'h0;
  endsequence

  byte_spacing_a: assert property (
    EE_WR_O && wr_seen_r && $past(wr_seen_r) |-> gap_r >= frl_pkg::BYTE_PROG_CYC)
    else $error("byte programs closer than the programming time");
  area_range_a: assert property (
    EE_WR_O |-> EE_ADDR_O >= frl_pkg::REC_BASE && EE_ADDR_O <= frl_pkg::REC_END)
    else $error("program outside the record area");
  flag_clear_a: assert property (
    EE_WR_O && EE_ADDR_O[2:0] == frl_pkg::FLAG_BYTE |-> !EE_WDATA_O[frl_pkg::FLAG_BIT])
    else $error("flag byte does not mark the slot used");
  order_start_a: assert property (s_capture |=> s_first_byte)
    else $error("record does not start at its lowest byte");
  trig_start_a: assert property (
    st_r == ST_IDLE && trig && !full_r && !rescan_r |=> st_r == ST_PREP)
    else $error("record state entry did not start a record");
  full_stop_a: assert property (
    full_r && st_r == ST_IDLE && !rescan_r |=> st_r == ST_IDLE)
    else $error("write started with every slot used");
  no_overlap_a: assert property (
    st_r == ST_WAIT |=> st_r inside {ST_WAIT, ST_PROG, ST_IDLE} && $stable(slot_r)
      || $past(byte_r) == frl_pkg::FLAG_BYTE)
    else $error("record interrupted before its last byte");
  scan_step_a: assert property (
    st_r == ST_SCAN_CHK && ee_rd_r && !EE_RDATA_I[frl_pkg::FLAG_BIT] && slot_r != '1
      |=> slot_r == $past(slot_r) + 1'b1 ##1 EE_RD_O)
    else $error("search did not move to the next slot");
  rescan_go_a: assert property (
    cmd_scan && st_r == ST_IDLE |-> ##[1:3] st_r == ST_SCAN_RD && slot_r == '0)
    else $error("search not repeated after recorder reset");
endmodule

// >>> testbench/frl_ee_model.sv
// Behavioural model of the nonvolatile byte array behind the logger
`timescale 1ns/100ps
module frl_ee_model (
  // Clock
  input wire logic clk_i,
  // Byte port from the logger
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  // ****************************************
  // Record area storage
  // ****************************************
  logic [7:0] mem [0:127]; // Bytes 0xf980 to 0xf9ff
  logic [7:0] junk_r; // Filler shown while no read is under way
  // Start erased, as the host leaves it
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'hff;
    end
    junk_r = 8'h00;
  end
  // Filler toggles every cycle so a read sampled outside its strobe sees 00 and ff in turn
  always @(posedge clk_i) begin
    junk_r <= ~junk_r;
    // Programming only clears bits; erase is the host's job
    if (wr_i) begin
      mem[addr_i[6:0]] <= mem[addr_i[6:0]] & wdata_i;
    end
  end
  // Read data stands while the strobe is high; the logger samples it at the edge ending it
  assign rdata_o = rd_i ? mem[addr_i[6:0]] : junk_r;
endmodule

// >>> testbench/frl_logger_tb.sv
// Self-checking bench for the fault record logger
`timescale 1ns/100ps
module frl_logger_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, rst, psel, pen, pwr, pready, pslverr, err;
  logic [7:0] paddr, uv, ov, lim, ee_wd, ee_rdata, sum;
  logic [31:0] pwdata, prdata, rd;
  logic step, ee_rd, ee_wr, busy;
  logic [frl_pkg::ST_W-1:0] st;
  logic [1:0] cause;
  logic [3:0] gpi;
  logic [15:0] ee_addr;
  logic [15:0] wa[$]; // Addresses programmed
  int wt[$]; // Cycle of each program strobe
  logic [7:0] b[8]; // Expected record bytes
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  // ****************************************
  // Design and array model
  // ****************************************
  frl_logger uut (.CLOCK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SEQ_STEP_I(step), .SEQ_STATE_I(st),
    .SEQ_CAUSE_I(cause), .UNDERVOLTAGE_STATUS_I(uv), .OVERVOLTAGE_STATUS_I(ov),
    .GENERAL_INPUT_LEVELS_I(gpi), .ADC_LIMIT_STATUS_I(lim), .EE_RD_O(ee_rd),
    .EE_WR_O(ee_wr), .EE_ADDR_O(ee_addr), .EE_WDATA_O(ee_wd), .EE_RDATA_I(ee_rdata),
    .REC_BUSY_O(busy));
  frl_ee_model ee (.clk_i(clk), .rd_i(ee_rd), .wr_i(ee_wr), .addr_i(ee_addr),
    .wdata_i(ee_wd), .rdata_o(ee_rdata));
  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Log every program strobe with its cycle
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ee_wr === 1'b1) begin
      wa.push_back(ee_addr);
      wt.push_back(cyc);
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // One-cycle sequencer step into state s
  task automatic go(input logic [4:0] s, input logic [1:0] c);
    @(posedge clk);
    step <= 1'b1;
    st <= s;
    cause <= c;
    @(posedge clk);
    step <= 1'b0;
  endtask
  // Restart the free-slot search and let it run over all sixteen slots
  task automatic research;
    apb(1'b1, frl_pkg::REG_CMD, 32'h1);
    repeat (60) @(posedge clk);
    apb(1'b0, frl_pkg::REG_STAT, 32'h0);
  endtask
  task automatic wrap_up;
    $display("Counts: %0d compared, %0d wrong", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog, about twice the expected run
  initial begin
    #(100 * 45000);
    bad_count++;
    wrap_up();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {rst, psel, pen, pwr, step} = 5'h10;
    {paddr, uv, ov, lim, pwdata} = '0;
    {st, cause, gpi} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (60) @(posedge clk);
    apb(1'b0, frl_pkg::REG_MASK, 32'h0);
    check(rd, frl_pkg::MASK_RST);
    apb(1'b0, 8'h0c, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b0, frl_pkg::REG_CMD, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, frl_pkg::REG_STAT, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
    // Slot 0 used: search must land on slot 1
    ee.mem[7] = 8'hfe;
    research();
    check(rd, 32'h81);
    apb(1'b1, frl_pkg::REG_MASK, 32'h8);
    apb(1'b0, frl_pkg::REG_MASK, 32'h0);
    check(rd, 32'h8);
    // Leave state 2 by timeout into record state 3
    go(5'h2, frl_pkg::CAUSE_SEQ);
    uv <= 8'h5a;
    ov <= 8'h3c;
    gpi <= 4'h9;
    lim <= 8'h81;
    go(5'h3, frl_pkg::CAUSE_TMO);
    {uv, ov, lim} <= '0;
    go(5'h4, frl_pkg::CAUSE_SEQ);
    go(5'h3, frl_pkg::CAUSE_MON);
    check({31'h0, busy}, 32'h1);
    // Status while programming: slot 1, busy and pending
    apb(1'b0, frl_pkg::REG_STAT, 32'h0);
    check(rd, 32'ha1);
    for (int i = 0; i < 30000 && busy !== 1'b0; i++) @(posedge clk);
    b = '{{frl_pkg::CAUSE_TMO, 6'h02}, 8'h5a, 8'h3c, 8'h09, 8'h81, 8'hff, 8'h00, 8'hfe};
    sum = 8'h00;
    for (int i = 0; i < 6; i++) begin
      sum = sum + b[i];
    end
    b[6] = 8'h00 - sum;
    check(32'(wa.size()), 32'h8);
    for (int i = 0; i < 8 && i < wa.size(); i++) begin
      check({16'h0, wa[i]}, 32'hf988 + i);
      check({24'h0, ee.mem[8 + i]}, {24'h0, b[i]});
      if (i > 0) begin
        // Programming time plus the one cycle that issues the next byte
        check(32'(wt[i] - wt[i - 1]), 32'(frl_pkg::BYTE_PROG_CYC + 1));
      end
    end
    apb(1'b0, frl_pkg::REG_STAT, 32'h0);
    check(rd, 32'h82);
    $display("test record done");
    // Every slot used: search reports full and triggers write nothing
    for (int s = 0; s < 16; s++) begin
      ee.mem[s * 8 + 7] = 8'hfe;
    end
    research();
    check({28'h0, rd[7:4]}, 32'h9);
    go(5'h3, frl_pkg::CAUSE_MON);
    repeat (40) @(posedge clk);
    check(32'(wa.size()), 32'h8);
    $display("test full done");
    // Host erases, then restarts the search
    for (int i = 0; i < 128; i++) begin
      ee.mem[i] = 8'hff;
    end
    research();
    check(rd, 32'h0);
    $display("test reuse done");
    wrap_up();
  end
endmodule
